// *** rtl/gmx_pkg.sv ***
// Operation
// [R01] Six pads, five through ten, each work as a plain line or as their mapped alternate.
// [R02] Pad functions exclude each other; a pad taken by a function is locked from line use.
// [R03] Each plain line is set to input or output on its own.
// [R04] Two-wire clock and data take over pads nine and ten when the bus is enabled.
// [R05] The bus runs only at 100 kbit/s or 400 kbit/s.
// [R06] The block is the only bus master and always drives the bus clock.
// [R07] The data line is driven by master or addressed slave, following transfer direction.
// [R08] Each slave is picked by a unique 7-bit address sent by the master.
// [R09] The block works as master transmitter (write) and master receiver (read).
// [R10] A slave sends or accepts data only when the master asks for a transfer.
// [R11] As jamming indicator, pad six is high for as long as jamming is detected.
// [R12] The jamming indicator is off after reset until configuration enables it.
// [R13] Pad five drives a status light showing the operating mode, excluding line use.
// [R14] The status light is enabled or disabled by configuration.
// [R15] Bus pads are only pulled low or released; pull-ups give the high level.
// [R16] Transfers use start, address with read/write bit, acknowledge per byte, and stop.
// [R17] With the jamming indicator enabled and no jamming, pad six is driven low.
package gmx_pkg;
  localparam int CLK_NS      = 50;
  localparam int LINK_CLK_NS = 48;
  localparam int STD_KBPS    = 100;
  localparam int FAST_KBPS   = 400;
  localparam int STD_BIT_NS  = 1000000 / STD_KBPS;
  localparam int FAST_BIT_NS = 1000000 / FAST_KBPS;
  // Quarter-bit counts round up so the bus never runs faster than its mode allows
  localparam int QTR_STD  = (STD_BIT_NS + 4 * LINK_CLK_NS - 1) / (4 * LINK_CLK_NS);
  localparam int QTR_FAST = (FAST_BIT_NS + 4 * LINK_CLK_NS - 1) / (4 * LINK_CLK_NS);
  localparam int QTR_W    = 6;

  localparam int LIGHT_SLOW_MS  = 500;
  localparam int LIGHT_FAST_MS  = 100;
  localparam int LIGHT_SLOW_CYC = LIGHT_SLOW_MS * 1000000 / CLK_NS;
  localparam int LIGHT_FAST_CYC = LIGHT_FAST_MS * 1000000 / CLK_NS;
  localparam int LIGHT_W        = 24;

  localparam int NUM_PADS  = 6;
  localparam int PAD_LIGHT = 0;
  localparam int PAD_JAM   = 1;
  localparam int PAD_SEVEN = 2;
  localparam int PAD_CLK   = 4;
  localparam int PAD_DAT   = 5;

  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [1:0] QTR_LAST = 2'h3;

  typedef enum logic [1:0] {
    LIGHT_OFF  = 2'b00,
    LIGHT_ON   = 2'b01,
    LIGHT_SLOW = 2'b10,
    LIGHT_FAST = 2'b11
  } gmx_light_mode_t;

  typedef enum logic [2:0] {
    TW_IDLE  = 3'b000,
    TW_START = 3'b001,
    TW_ADDR  = 3'b010,
    TW_DATA  = 3'b011,
    TW_STOP  = 3'b100
  } gmx_tw_state_t;

  typedef struct packed {
    logic drive;
    logic enable;
  } gmx_pad_t;

  typedef struct packed {
    logic [5:0] gpio_dir;
    logic [5:0] gpio_out;
    logic       light_en;
    logic       jam_en;
    logic       two_wire_en;
    logic       fast_mode;
  } gmx_cfg_t;

  typedef struct packed {
    logic [6:0] addr;
    logic       rnw;
    logic [7:0] wdata;
  } gmx_cmd_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       addr_ack;
    logic       data_ack;
  } gmx_rsp_t;

  localparam gmx_cfg_t CFG_RESET = '0;
  localparam gmx_rsp_t RSP_RESET = '0;
endpackage : gmx_pkg

// *** rtl/gmx_top.sv ***
`timescale 1ns/1ns
module gmx_top #(
  parameter int unsigned SLOW_HALF_CYC = gmx_pkg::LIGHT_SLOW_CYC,
  parameter int unsigned FAST_HALF_CYC = gmx_pkg::LIGHT_FAST_CYC
) (
  input  logic                     clk,
  input  logic                     rst_b,
  input  logic                     link_clk,
  input  gmx_pkg::gmx_cfg_t        cfg,
  input  gmx_pkg::gmx_light_mode_t op_mode,
  input  logic                     jam_detect,
  output logic [5:0]               gpio_level,
  input  logic                     cmd_valid,
  output logic                     cmd_ready,
  input  gmx_pkg::gmx_cmd_t        cmd,
  output logic                     rsp_valid,
  output gmx_pkg::gmx_rsp_t        rsp,
  input  logic                     io_line_five_light_lvl,
  input  logic                     io_line_six_jam_lvl,
  input  logic                     io_line_seven_lvl,
  input  logic                     io_line_eight_lvl,
  input  logic                     io_line_nine_clk_lvl,
  input  logic                     io_line_ten_dat_lvl,
  output gmx_pkg::gmx_pad_t        io_line_five_light,
  output gmx_pkg::gmx_pad_t        io_line_six_jam,
  output gmx_pkg::gmx_pad_t        io_line_seven,
  output gmx_pkg::gmx_pad_t        io_line_eight,
  output gmx_pkg::gmx_pad_t        io_line_nine_clk,
  output gmx_pkg::gmx_pad_t        io_line_ten_dat
);
  import gmx_pkg::*;

  // ----------------------------------------------------------------
  // Resets
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic [1:0] lrst_pipe;
  logic       rst_n;
  logic       lrst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rst_pipe <= 2'h0;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) lrst_pipe <= 2'h0;
    else lrst_pipe <= {lrst_pipe[0], 1'b1};
  end

  assign rst_n  = rst_pipe[1];
  assign lrst_n = lrst_pipe[1];

  // ----------------------------------------------------------------
  // Configuration and pad inputs
  // ----------------------------------------------------------------
  gmx_cfg_t   cfg_q;
  logic [5:0] pad_lvl;
  logic [5:0] in_meta;
  logic [5:0] in_sync;
  logic [5:0] taken;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cfg_q <= CFG_RESET; // R12
    else cfg_q <= cfg;
  end

  assign pad_lvl = {io_line_ten_dat_lvl, io_line_nine_clk_lvl, io_line_eight_lvl,
                    io_line_seven_lvl, io_line_six_jam_lvl, io_line_five_light_lvl};

  always_comb begin
    taken            = 6'h00;
    taken[PAD_LIGHT] = cfg_q.light_en;    // R13
    taken[PAD_JAM]   = cfg_q.jam_en;
    taken[PAD_CLK]   = cfg_q.two_wire_en; // R04
    taken[PAD_DAT]   = cfg_q.two_wire_en;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta    <= 6'h00;
      in_sync    <= 6'h00;
      gpio_level <= 6'h00;
    end else begin
      in_meta    <= pad_lvl;
      in_sync    <= in_meta;
      gpio_level <= in_sync & ~taken; // R02
    end
  end

  // ----------------------------------------------------------------
  // Status light and jamming indicator
  // ----------------------------------------------------------------
  logic [LIGHT_W-1:0] blink_cnt;
  logic               blink_phase;
  logic               light_lvl;
  logic               jam_q;
  logic [LIGHT_W-1:0] half_lim;

  assign half_lim = (op_mode == LIGHT_FAST) ? LIGHT_W'(FAST_HALF_CYC - 1)
                                            : LIGHT_W'(SLOW_HALF_CYC - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt   <= '0;
      blink_phase <= 1'b0;
    end else if (blink_cnt >= half_lim) begin
      blink_cnt   <= '0;
      blink_phase <= ~blink_phase;
    end else begin
      blink_cnt <= blink_cnt + LIGHT_W'(1);
    end
  end

  always_comb begin
    case (op_mode)
      LIGHT_OFF: light_lvl = 1'b0;
      LIGHT_ON:  light_lvl = 1'b1;
      default:   light_lvl = blink_phase; // R13
    endcase
  end

  // Held only while detection persists; no stretching of short events
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) jam_q <= 1'b0;
    else jam_q <= jam_detect; // R11
  end

  // ----------------------------------------------------------------
  // Command crossing (toggle handshake)
  // ----------------------------------------------------------------
  logic     req_tog;
  gmx_cmd_t cmd_q;
  logic     done_tog;
  logic     done_meta;
  logic     done_s;
  logic     done_d;
  logic     busy;
  logic     done_evt;
  gmx_rsp_t rsp_link;

  assign busy      = req_tog ^ done_s;
  assign done_evt  = done_s ^ done_d;
  assign cmd_ready = !busy && cfg_q.two_wire_en;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_tog <= 1'b0;
      cmd_q   <= '0;
    end else if (cmd_valid && cmd_ready) begin
      req_tog <= ~req_tog;
      cmd_q   <= cmd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_meta <= 1'b0;
      done_s    <= 1'b0;
      done_d    <= 1'b0;
      rsp_valid <= 1'b0;
      rsp       <= RSP_RESET;
    end else begin
      done_meta <= done_tog;
      done_s    <= done_meta;
      done_d    <= done_s;
      rsp_valid <= done_evt;
      if (done_evt) rsp <= rsp_link;
    end
  end

  // ----------------------------------------------------------------
  // Two-wire master engine (link clock)
  // ----------------------------------------------------------------
  gmx_tw_state_t    state;
  gmx_cmd_t         lcmd;
  logic             req_meta;
  logic             req_s;
  logic             req_d;
  logic             fast_meta;
  logic             fast_s;
  logic             sda_meta;
  logic             sda_s;
  logic [QTR_W-1:0] qcnt;
  logic [QTR_W-1:0] qtr_lim;
  logic [1:0]       qph;
  logic [3:0]       bitn;
  logic [7:0]       shreg;
  logic             tick;
  logic             bit_end;
  logic             two_wire_clock;
  logic             two_wire_data;

  function automatic logic byte_out(gmx_tw_state_t st, logic rnw);
    return (st == TW_ADDR) || ((st == TW_DATA) && !rnw);
  endfunction : byte_out

  assign tick    = (qcnt == '0);
  assign bit_end = tick && (qph == QTR_LAST);
  assign qtr_lim = fast_s ? QTR_W'(QTR_FAST) : QTR_W'(QTR_STD); // R05

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      req_meta  <= 1'b0;
      req_s     <= 1'b0;
      req_d     <= 1'b0;
      fast_meta <= 1'b0;
      fast_s    <= 1'b0;
      sda_meta  <= 1'b1;
      sda_s     <= 1'b1;
    end else begin
      req_meta  <= req_tog;
      req_s     <= req_meta;
      req_d     <= req_s;
      fast_meta <= cfg_q.fast_mode;
      fast_s    <= fast_meta;
      sda_meta  <= io_line_ten_dat_lvl;
      sda_s     <= sda_meta;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      qcnt <= '0;
      qph  <= 2'h0;
    end else if (state == TW_IDLE) begin
      qcnt <= qtr_lim - QTR_W'(1);
      qph  <= 2'h0;
    end else if (tick) begin
      qcnt <= qtr_lim - QTR_W'(1);
      qph  <= qph + 2'h1;
    end else begin
      qcnt <= qcnt - QTR_W'(1);
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      state    <= TW_IDLE;
      lcmd     <= '0;
      done_tog <= 1'b0;
    end else begin
      case (state)
        TW_IDLE: if (req_s ^ req_d) begin // R10
          state <= TW_START;
          lcmd  <= cmd_q;
        end
        TW_START: if (bit_end) state <= TW_ADDR;
        TW_ADDR: if (bit_end && bitn == BIT_ACK) begin
          // Unanswered address skips the data byte
          state <= rsp_link.addr_ack ? TW_DATA : TW_STOP; // R09
        end
        TW_DATA: if (bit_end && bitn == BIT_ACK) state <= TW_STOP;
        TW_STOP: if (bit_end) begin
          state    <= TW_IDLE;
          done_tog <= ~done_tog;
        end
        default: state <= TW_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      bitn     <= 4'h0;
      shreg    <= 8'h00;
      rsp_link <= RSP_RESET;
    end else if (state == TW_IDLE) begin
      bitn <= 4'h0;
      // Last answer must stand until the clock side has taken it; clear on the next command
      if (req_s ^ req_d) rsp_link <= RSP_RESET;
    end else if (state == TW_START && bit_end) begin
      shreg <= {lcmd.addr, lcmd.rnw}; // R08
      bitn  <= 4'h0;
    end else if (tick && (state == TW_ADDR || state == TW_DATA)) begin
      if (qph == 2'h2 && bitn == BIT_ACK && byte_out(state, lcmd.rnw)) begin
        if (state == TW_ADDR) rsp_link.addr_ack <= !sda_s; // R16
        else rsp_link.data_ack <= !sda_s;
      end else if (qph == 2'h2 && bitn != BIT_ACK && !byte_out(state, lcmd.rnw)) begin
        rsp_link.rdata <= {rsp_link.rdata[6:0], sda_s}; // R09
      end
      if (qph == QTR_LAST) begin
        if (bitn == BIT_ACK) begin
          bitn  <= 4'h0;
          shreg <= lcmd.wdata;
        end else begin
          bitn  <= bitn + 4'h1;
          shreg <= {shreg[6:0], 1'b0};
        end
      end
    end
  end

  // Lines are only ever pulled low; a released line is high via pull-up
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      two_wire_clock <= 1'b0;
      two_wire_data  <= 1'b0;
    end else if (tick) begin
      case (state)
        TW_START: begin
          if (qph == 2'h1) two_wire_data <= 1'b1; // R16
          if (qph == 2'h2) two_wire_clock <= 1'b1;
        end
        TW_ADDR, TW_DATA: begin
          case (qph)
            2'h0: begin
              two_wire_clock <= 1'b1;
              // Ack slots and read bits release data for the slave
              two_wire_data  <= byte_out(state, lcmd.rnw) && bitn != BIT_ACK
                                && !shreg[7]; // R07
            end
            2'h1:    two_wire_clock <= 1'b0; // R06
            default: two_wire_clock <= 1'b1;
          endcase
        end
        TW_STOP: begin
          case (qph)
            2'h0: begin
              two_wire_clock <= 1'b1;
              two_wire_data  <= 1'b1;
            end
            2'h1:    two_wire_clock <= 1'b0;
            2'h2:    two_wire_data  <= 1'b0; // R16
            default: two_wire_data  <= 1'b0;
          endcase
        end
        default: begin
          two_wire_clock <= 1'b0;
          two_wire_data  <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pad output mux
  // ----------------------------------------------------------------
  logic [5:0] pad_drive;
  logic [5:0] pad_en;

  always_comb begin
    pad_drive = cfg_q.gpio_out & cfg_q.gpio_dir; // R03
    pad_en    = cfg_q.gpio_dir;                  // R01
    if (cfg_q.light_en) begin // R14
      pad_drive[PAD_LIGHT] = light_lvl;
      pad_en[PAD_LIGHT]    = 1'b1;
    end
    if (cfg_q.jam_en) begin
      pad_drive[PAD_JAM] = jam_q; // R17
      pad_en[PAD_JAM]    = 1'b1;
    end
    if (cfg_q.two_wire_en) begin
      pad_drive[PAD_CLK] = 1'b0; // R15
      pad_en[PAD_CLK]    = two_wire_clock;
      pad_drive[PAD_DAT] = 1'b0;
      pad_en[PAD_DAT]    = two_wire_data;
    end
  end

  assign io_line_five_light = '{drive: pad_drive[0], enable: pad_en[0]};
  assign io_line_six_jam    = '{drive: pad_drive[1], enable: pad_en[1]};
  assign io_line_seven      = '{drive: pad_drive[2], enable: pad_en[2]};
  assign io_line_eight      = '{drive: pad_drive[3], enable: pad_en[3]};
  assign io_line_nine_clk   = '{drive: pad_drive[4], enable: pad_en[4]};
  assign io_line_ten_dat    = '{drive: pad_drive[5], enable: pad_en[5]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_start_pull;
    state == TW_START && tick && qph == 2'h1;
  endsequence

  sequence seq_stop_release;
    state == TW_STOP && tick && qph == 2'h2;
  endsequence

  chk_jam_high: assert property (@(posedge clk) disable iff (!rst_n) // R11
    cfg_q.jam_en && jam_detect |=> io_line_six_jam.enable && io_line_six_jam.drive)
    else $error("jam pad not high while jamming");
  chk_jam_low: assert property (@(posedge clk) disable iff (!rst_n) // R17
    cfg_q.jam_en && !jam_q |-> io_line_six_jam.enable && !io_line_six_jam.drive)
    else $error("jam pad not low without jamming");
  chk_jam_reset: assert property (@(posedge clk) // R12
    $rose(rst_n) |-> !cfg_q.jam_en && !io_line_six_jam.enable)
    else $error("jam indicator active after reset");
  chk_gpio_lock: assert property (@(posedge clk) disable iff (!rst_n) // R02
    cfg_q.two_wire_en |=> gpio_level[PAD_CLK] == 1'b0 && gpio_level[PAD_DAT] == 1'b0)
    else $error("taken pad visible as line");
  chk_gpio_out: assert property (@(posedge clk) disable iff (!rst_n) // R03
    cfg_q.gpio_dir[PAD_SEVEN] |-> io_line_seven.enable
      && io_line_seven.drive == cfg_q.gpio_out[PAD_SEVEN])
    else $error("line seven output wrong");
  chk_open_drain: assert property (@(posedge clk) disable iff (!rst_n) // R15
    cfg_q.two_wire_en |-> !io_line_nine_clk.drive && !io_line_ten_dat.drive)
    else $error("bus pad driven high");
  chk_start_cond: assert property (@(posedge link_clk) disable iff (!lrst_n) // R16
    seq_start_pull |=> two_wire_data && !two_wire_clock)
    else $error("start condition wrong");
  chk_stop_cond: assert property (@(posedge link_clk) disable iff (!lrst_n) // R16
    seq_stop_release |=> !two_wire_data && !two_wire_clock)
    else $error("stop condition wrong");
  chk_scl_high_min: assert property (@(posedge link_clk) disable iff (!lrst_n) // R05
    $fell(two_wire_clock) |-> !two_wire_clock [*8])
    else $error("bus clock high too short");
  chk_ack_release: assert property (@(posedge link_clk) disable iff (!lrst_n) // R07
    state == TW_ADDR && bitn == BIT_ACK && qph == 2'h2 |-> !two_wire_data)
    else $error("data held during address ack");
endmodule : gmx_top

// *** verification/gmx_slave_model.sv ***
`timescale 1ns/1ns
module gmx_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] rd_byte,
  output logic            sda_pull,
  output logic [7:0]      got_byte
);
  logic [3:0] bitn = 4'hf;
  logic [7:0] sh = 8'h00;
  logic       active = 1'b0;
  logic       in_data = 1'b0;
  logic       sel = 1'b0;
  logic       rd = 1'b0;

  initial begin
    sda_pull = 1'b0;
    got_byte = 8'h00;
  end

  // ------------------------------------------------------------
  // Framing
  // ------------------------------------------------------------
  always @(negedge sda) begin
    if (scl) begin
      active = 1'b1;
      bitn = 4'hf;
      in_data = 1'b0;
      sel = 1'b0;
    end
  end

  always @(posedge sda) begin
    if (scl) begin
      active = 1'b0;
      sda_pull = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Bit engine: no clock of its own, it follows the master only
  // ------------------------------------------------------------
  always @(posedge scl) begin
    // A released ack after a read byte ends our part of the transfer
    if (active && in_data && rd && bitn == 4'h8 && sda) active = 1'b0;
    if (active && bitn < 4'h8) begin
      sh = {sh[6:0], sda};
      if (bitn == 4'h7 && !in_data) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
      end
      if (bitn == 4'h7 && in_data && sel && !rd) begin
        got_byte = sh;
      end
    end
  end

  always @(negedge scl) begin
    if (active) begin
      if (bitn == 4'h8) begin
        bitn = 4'h0;
        in_data = 1'b1;
      end else begin
        bitn = bitn + 4'h1;
      end
      // Ack the address and written data; drive read bits, leave the master's ack alone
      sda_pull = sel && ((bitn == 4'h8 && !(in_data && rd)) ||
                 (in_data && rd && bitn < 4'h8 && !rd_byte[3'h7 - bitn[2:0]]));
    end
  end
endmodule : gmx_slave_model

// *** verification/gmx_top_tb.sv ***
`timescale 1ns/1ns
module gmx_top_tb;
  import gmx_pkg::*;
  localparam int         SLOW_H = 8;
  localparam int         FAST_H = 4;
  localparam logic [7:0] RD     = 8'hc5;
  logic              clk;
  logic              link_clk;
  logic              rst_b;
  gmx_cfg_t          cfg;
  gmx_light_mode_t   op_mode;
  logic              jam_detect;
  logic [5:0]        gpio_level;
  logic              cmd_valid;
  logic              cmd_ready;
  gmx_cmd_t          cmd;
  logic              rsp_valid;
  gmx_rsp_t          rsp;
  gmx_pad_t          pad [6];
  wire logic [5:0]   lvl;
  logic [5:0]        ext;
  logic              sda_pull;
  logic [7:0]        got_byte;
  logic              od_bad = 1'b0;
  int                nfall = 0;
  int                n_errors = 0;
  int                checks_done = 0;

  // ------------------------------------------------------------
  // Clocks, pads and partner
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  // Undriven pads show the outside level; bus pads sit on pull-ups
  for (genvar i = 0; i < 6; i++) begin : g_lvl
    assign lvl[i] = pad[i].enable ? pad[i].drive : ((i == 5) ? (ext[i] & ~sda_pull) : ext[i]);
  end

  always @(negedge lvl[4]) nfall++;

  always @(posedge clk) begin
    if (cfg.two_wire_en && (pad[4].drive || pad[5].drive)) od_bad <= 1'b1;
  end

  gmx_top #(.SLOW_HALF_CYC(SLOW_H), .FAST_HALF_CYC(FAST_H)) gmx_top_inst (
    .clk(clk), .rst_b(rst_b), .link_clk(link_clk), .cfg(cfg), .op_mode(op_mode),
    .jam_detect(jam_detect), .gpio_level(gpio_level), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp),
    .io_line_five_light_lvl(lvl[0]), .io_line_six_jam_lvl(lvl[1]),
    .io_line_seven_lvl(lvl[2]), .io_line_eight_lvl(lvl[3]),
    .io_line_nine_clk_lvl(lvl[4]), .io_line_ten_dat_lvl(lvl[5]),
    .io_line_five_light(pad[0]), .io_line_six_jam(pad[1]), .io_line_seven(pad[2]),
    .io_line_eight(pad[3]), .io_line_nine_clk(pad[4]), .io_line_ten_dat(pad[5]));

  gmx_slave_model #(.ADDR(7'h2a)) gmx_slave_model_inst (
    .scl(lvl[4]), .sda(lvl[5]), .rd_byte(RD), .sda_pull(sda_pull), .got_byte(got_byte));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL at %0t ns: %s", $time, what);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 6; i++) chk(pad[i].enable, 1'b0, "pad driven in reset");
    chk(gpio_level, 6'h00, "level in reset");
    chk({rsp_valid, cmd_ready}, 2'b00, "bus active in reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_lines;
    logic [5:0] d;
    logic [5:0] o;
    for (int k = 0; k < 2; k++) begin
      d = k ? 6'h2a : 6'h15;
      o = k ? 6'h3c : 6'h33;
      cfg.gpio_dir = d;
      cfg.gpio_out = o;
      ext = k ? 6'h30 : 6'h0f;
      repeat (6) @(negedge clk);
      for (int i = 0; i < 6; i++) chk(pad[i], {o[i] & d[i], d[i]}, "line pad");
      chk(gpio_level, (o & d) | (ext & ~d), "line levels");
    end
    ext = 6'h3f;
    $display("test lines done");
  endtask : t_lines

  task automatic t_jam;
    cfg = CFG_RESET;
    cfg.gpio_dir = 6'h02;
    cfg.gpio_out = 6'h02;
    cfg.jam_en = 1'b1;
    repeat (6) @(negedge clk);
    chk(pad[1], 2'b01, "jam idle");
    chk(gpio_level[1], 1'b0, "jam pad level");
    jam_detect = 1'b1;
    chk(pad[1].drive, 1'b0, "jam too early");
    @(negedge clk);
    chk(pad[1], 2'b11, "jam shown");
    repeat (6) @(negedge clk);
    chk(pad[1], 2'b11, "jam held");
    jam_detect = 1'b0;
    @(negedge clk);
    chk(pad[1], 2'b01, "jam cleared");
    cfg = CFG_RESET;
    $display("test jam done");
  endtask : t_jam

  task automatic t_light;
    int   ch;
    logic prev;
    cfg.gpio_dir = 6'h01;
    cfg.light_en = 1'b1;
    op_mode = LIGHT_ON;
    repeat (3) @(negedge clk);
    chk(pad[0], 2'b11, "light on");
    op_mode = LIGHT_OFF;
    @(negedge clk);
    chk(pad[0], 2'b01, "light off");
    for (int m = 0; m < 2; m++) begin
      op_mode = m ? LIGHT_FAST : LIGHT_SLOW;
      @(negedge clk);
      prev = pad[0].drive;
      ch = 0;
      repeat (64) begin
        @(negedge clk);
        if (pad[0].drive !== prev) ch++;
        prev = pad[0].drive;
      end
      chk(ch >= 64 / (m ? FAST_H : SLOW_H) - 1 && ch <= 64 / (m ? FAST_H : SLOW_H) + 1, 1,
          "blink rate");
    end
    op_mode = LIGHT_ON;
    cfg.light_en = 1'b0;
    repeat (3) @(negedge clk);
    chk(pad[0], 2'b01, "light disabled");
    cfg = CFG_RESET;
    $display("test light done");
  endtask : t_light

  task automatic t_bus(input logic fast, input logic [6:0] a, input logic rnw,
                       input logic [7:0] wd);
    logic hit;
    int   n;
    int   bit_ns;
    int   u;
    hit = (a == 7'h2a);
    bit_ns = fast ? FAST_BIT_NS : STD_BIT_NS;
    u = hit ? 20 : 11;
    cfg.fast_mode = fast;
    cfg.two_wire_en = 1'b1;
    repeat (6) @(negedge clk);
    chk(gpio_level[5:4], 2'b00, "bus pads read");
    nfall = 0;
    cmd = '{addr: a, rnw: rnw, wdata: wd};
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    chk(cmd_ready, 1'b0, "ready while busy");
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk(rsp_valid, 1'b1, "no answer");
    chk(n * CLK_NS >= (u - 1) * bit_ns && n * CLK_NS <= (u + 3) * bit_ns, 1,
        "bus rate");
    chk(rsp.addr_ack, hit, "address ack");
    chk(rsp.data_ack, hit && !rnw, "data ack");
    chk(rsp.rdata, (hit && rnw) ? RD : 8'h00, "read data");
    chk(nfall, hit ? 19 : 10, "clock pulses");
    if (hit && !rnw) chk(got_byte, wd, "written byte");
    repeat (3) @(negedge clk);
    chk(lvl[5:4], 2'b11, "bus released");
    chk(od_bad, 1'b0, "bus pad driven high");
    $display("test bus done");
  endtask : t_bus

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    cfg = CFG_RESET;
    op_mode = LIGHT_OFF;
    jam_detect = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    ext = 6'h3f;
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    t_reset;
    rst_b = 1'b1;
    jam_detect = 1'b1;
    repeat (5) @(negedge clk);
    chk(pad[1].enable, 1'b0, "jam before enable");
    jam_detect = 1'b0;
    t_lines;
    t_jam;
    t_light;
    t_bus(1'b0, 7'h2a, 1'b0, 8'h96);
    t_bus(1'b1, 7'h2a, 1'b1, 8'h00);
    t_bus(1'b1, 7'h15, 1'b0, 8'h5a);
    t_bus(1'b0, 7'h2a, 1'b1, 8'h00);
    report_and_stop;
  end

  initial begin
    #3000000;
    n_errors++;
    report_and_stop;
  end
endmodule : gmx_top_tb
